// ==== rtl/rss_params.svh ====
// Offsets, field positions, reset values and timing counts of the reset sequencer
`ifndef RSS_PARAMS_SVH
`define RSS_PARAMS_SVH

`define RSS_CLK_MHZ 100
`define RSS_ADDR_W 2
`define RSS_OFF_CAUSE 2'h0
`define RSS_OFF_IRQ_STATUS 2'h1
`define RSS_OFF_IRQ_MASK 2'h2

`define RSS_BIT_POR 0
`define RSS_BIT_EXT 1
`define RSS_BIT_BOD 2
`define RSS_BIT_WDT 3
`define RSS_BIT_TST 4
`define RSS_NSRC 5
`define RSS_LEGACY_MASK 5'h03
`define RSS_FLAGS_RST 5'h00
`define RSS_MASK_RST 5'h00

`define RSS_PIN_MIN_NS 50
`define RSS_PIN_MIN_CYC ((`RSS_PIN_MIN_NS * `RSS_CLK_MHZ + 999) / 1000)
`define RSS_BOD_MIN_NS 2000
`define RSS_BOD_MIN_CYC ((`RSS_BOD_MIN_NS * `RSS_CLK_MHZ + 999) / 1000)

`define RSS_TOUT_FAST_US 4100
`define RSS_TOUT_SLOW_US 65000
`define RSS_TOUT_FAST_CYC (`RSS_TOUT_FAST_US * `RSS_CLK_MHZ)
`define RSS_TOUT_SLOW_CYC (`RSS_TOUT_SLOW_US * `RSS_CLK_MHZ)
`define RSS_TOUT_NONE_CYC 1
`define RSS_FUSE_NO_DELAY 4'h0

`endif

// ==== rtl/rss_pkg.sv ====
// Types shared by the reset source sequencer
package rss_pkg;
  typedef enum logic [1:0] {
    RSS_RUN = 2'b00,
    RSS_HOLD = 2'b01,
    RSS_STRETCH = 2'b11
  } rss_state_type;

  typedef logic [4:0] rss_src_type;
  typedef logic [1:0] rss_addr_type;
  typedef logic [23:0] rss_count_type;
endpackage

// ==== rtl/rss_reset_source_sequencer.sv ====
// Reset source sequencer: combines reset requests, stretches reset, records cause
//
// Summary of operation
// - While reset holds, I/O registers load initial values; release starts fetch at vector.
// - Any raw reset source forces I/O ports to initial state without a clock.
// - After all sources drop, reset stays for a delay chosen by clock select fuses.
// - Five sources: power-on, pin, watchdog, brown-out, test port; any one resets.
// - A long enough low on the reset pin resets; shorter pulses may be ignored.
// - When the reset pin returns high, the full delay runs before release.
// - Reset holds while the test-port reset bit is one; once zero the delay runs before release.
// - Low supply resets at once; when it clears the delay runs before release.
// - Enabled brown-out resets at once; on recovery the delay runs before release.
// - A brown-out counts only if low supply persists past a minimum period.
// - Watchdog timeout is a one-cycle pulse; delay starts when it falls.
// - Cause bit 4 set by test-port reset; cleared by brown-out or zero write.
// - Cause bit 3 set by watchdog reset; cleared by power-on or zero write.
// - Cause bit 2 set by brown-out reset; cleared by power-on or zero write.
// - Cause bit 1 set by pin reset; cleared by power-on or zero write.
// - Cause bit 0 set by power-on reset; cleared only by a zero write.
// - With the legacy fuse, only pin and power-on cause bits exist.
`timescale 1ns/100ps
`include "rss_params.svh"

module rss_reset_source_sequencer #(
  parameter logic [23:0] TOUT_FAST_CYC = 24'(`RSS_TOUT_FAST_CYC),
  parameter logic [23:0] TOUT_SLOW_CYC = 24'(`RSS_TOUT_SLOW_CYC)
) (
  input wire logic core_clk_in, // System clock, 100 MHz
  input wire logic rst_in, // Synchronous reset, active high
  input wire logic supply_low_in, // Power-on detector, high while supply low
  input wire logic ext_reset_n_in, // External reset pin, active low
  input wire logic wdt_timeout_in, // Watchdog timeout, one-cycle pulse
  input wire logic brownout_detector_in, // High while supply under trigger
  input wire logic test_port_reset_in, // Test-port reset register bit
  input wire logic [3:0] clock_select_fuses_in, // Delay selection fuses
  input wire logic brownout_enable_fuse_in, // Brown-out detection enable
  input wire logic legacy_fuse_in, // Legacy compatibility fuse
  input wire rss_pkg::rss_addr_type reg_addr_in, // Register address
  input wire logic [7:0] reg_wdata_in, // Register write data
  input wire logic reg_wr_in, // Write strobe
  input wire logic reg_rd_in, // Read strobe
  output logic [7:0] reg_rdata_out, // Read data, cycle after strobe
  output logic io_force_init_out, // Asynchronous I/O port reset
  output logic internal_reset_out, // Stretched internal reset
  output logic io_load_init_out, // I/O registers load initial values
  output logic fetch_vector_out, // Pulse: start fetch at reset vector
  output logic irq_out // Level interrupt, unmasked cause event
);
  import rss_pkg::*;

  localparam logic [2:0] PIN_MIN = 3'(`RSS_PIN_MIN_CYC);
  localparam logic [7:0] BOD_MIN = 8'(`RSS_BOD_MIN_CYC);
  localparam logic [23:0] TOUT_NONE = 24'(`RSS_TOUT_NONE_CYC);

  typedef struct packed {
    logic [1:0] por_sync;
    logic [1:0] pin_sync;
    logic [1:0] bod_sync;
    logic [1:0] tst_sync;
    logic [2:0] pin_cnt;
    logic [7:0] bod_cnt;
    logic ext_req;
    logic bod_req;
    rss_src_type req_prev;
    rss_state_type state;
    rss_count_type cnt;
    rss_src_type flags;
    rss_src_type irq_status;
    rss_src_type irq_mask;
    logic [7:0] rdata;
    logic fetch;
    logic int_rst;
  } rss_regs_type;

  rss_regs_type r_q;
  rss_regs_type r_d;

  // Stretch length picked by the fuses
  function automatic rss_count_type tout_sel(input logic [3:0] fuses);
    if (fuses == `RSS_FUSE_NO_DELAY) begin
      return TOUT_NONE;
    end
    return fuses[0] ? TOUT_SLOW_CYC : TOUT_FAST_CYC;
  endfunction

  // Write strobe aimed at one register offset
  function automatic logic wr_hit(input logic wr, input rss_addr_type addr,
    input rss_addr_type off);
    return wr && (addr == off);
  endfunction

  // Cause bits that exist under the current fuse setting
  function automatic rss_src_type avail(input logic legacy);
    return legacy ? `RSS_LEGACY_MASK : {`RSS_NSRC{1'b1}};
  endfunction

  rss_src_type req;
  rss_src_type rise;
  rss_src_type wr_keep;
  logic any_req;

  // Raw pins straight to the port reset: must work with the clock stopped
  assign io_force_init_out = supply_low_in | ~ext_reset_n_in | wdt_timeout_in
    | (brownout_enable_fuse_in & brownout_detector_in) | test_port_reset_in;

  always_comb begin
    r_d = r_q;
    req = '0;
    rise = '0;
    wr_keep = '1;
    any_req = 1'b0;

    r_d.por_sync = {r_q.por_sync[0], supply_low_in};
    r_d.pin_sync = {r_q.pin_sync[0], ext_reset_n_in};
    r_d.bod_sync = {r_q.bod_sync[0], brownout_detector_in};
    r_d.tst_sync = {r_q.tst_sync[0], test_port_reset_in};

    // Pin must stay low for the minimum width before it counts
    if (!r_q.pin_sync[1]) begin
      if (r_q.pin_cnt != PIN_MIN) begin
        r_d.pin_cnt = r_q.pin_cnt + 3'h1;
      end
    end else begin
      r_d.pin_cnt = '0;
    end
    r_d.ext_req = !r_q.pin_sync[1] && (r_q.pin_cnt == PIN_MIN);

    // Short dips are filtered; a disabled detector never requests
    if (brownout_enable_fuse_in && r_q.bod_sync[1]) begin
      if (r_q.bod_cnt != BOD_MIN) begin
        r_d.bod_cnt = r_q.bod_cnt + 8'h01;
      end
    end else begin
      r_d.bod_cnt = '0;
    end
    r_d.bod_req = brownout_enable_fuse_in && r_q.bod_sync[1]
      && (r_q.bod_cnt == BOD_MIN);

    req[`RSS_BIT_POR] = r_q.por_sync[1];
    req[`RSS_BIT_EXT] = r_q.ext_req;
    req[`RSS_BIT_BOD] = r_q.bod_req;
    req[`RSS_BIT_WDT] = wdt_timeout_in;
    req[`RSS_BIT_TST] = r_q.tst_sync[1];
    any_req = |req;
    rise = req & ~r_q.req_prev;
    r_d.req_prev = req;

    // Any request holds; the count only runs once all are gone
    unique case (r_q.state)
      RSS_RUN: begin
        if (any_req) begin
          r_d.state = RSS_HOLD;
        end
      end
      RSS_HOLD: begin
        r_d.cnt = tout_sel(clock_select_fuses_in);
        if (!any_req) begin
          r_d.state = RSS_STRETCH;
        end
      end
      RSS_STRETCH: begin
        if (any_req) begin
          r_d.state = RSS_HOLD;
        end else if (r_q.cnt <= 24'h000001) begin
          r_d.state = RSS_RUN;
        end else begin
          r_d.cnt = r_q.cnt - 24'h000001;
        end
      end
      default: begin
        r_d.state = RSS_HOLD;
      end
    endcase
    r_d.int_rst = (r_d.state != RSS_RUN);
    r_d.fetch = (r_q.state == RSS_STRETCH) && (r_d.state == RSS_RUN);

    // Zero writes clear a cause bit, ones leave it alone
    if (wr_hit(reg_wr_in, reg_addr_in, `RSS_OFF_CAUSE)) begin
      wr_keep = reg_wdata_in[4:0];
    end
    r_d.flags = r_q.flags & wr_keep;
    if (rise[`RSS_BIT_POR]) begin
      r_d.flags[`RSS_BIT_EXT] = 1'b0;
      r_d.flags[`RSS_BIT_BOD] = 1'b0;
      r_d.flags[`RSS_BIT_WDT] = 1'b0;
    end
    if (rise[`RSS_BIT_BOD]) begin
      r_d.flags[`RSS_BIT_TST] = 1'b0;
    end
    // Setting comes last so an event in the clearing cycle survives
    r_d.flags = (r_d.flags | rise) & avail(legacy_fuse_in);

    r_d.irq_status = r_q.irq_status;
    if (wr_hit(reg_wr_in, reg_addr_in, `RSS_OFF_IRQ_STATUS)) begin
      r_d.irq_status = r_q.irq_status & ~reg_wdata_in[4:0];
    end
    r_d.irq_status = (r_d.irq_status | rise) & avail(legacy_fuse_in);
    if (wr_hit(reg_wr_in, reg_addr_in, `RSS_OFF_IRQ_MASK)) begin
      r_d.irq_mask = reg_wdata_in[4:0];
    end

    r_d.rdata = '0;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `RSS_OFF_CAUSE: r_d.rdata = {3'h0, r_q.flags};
        `RSS_OFF_IRQ_STATUS: r_d.rdata = {3'h0, r_q.irq_status};
        `RSS_OFF_IRQ_MASK: r_d.rdata = {3'h0, r_q.irq_mask};
        default: r_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      r_q <= '0;
      r_q.pin_sync <= 2'b11;
      r_q.state <= RSS_HOLD;
      r_q.cnt <= TOUT_NONE;
      r_q.flags <= `RSS_FLAGS_RST;
      r_q.irq_mask <= `RSS_MASK_RST;
      r_q.int_rst <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  assign reg_rdata_out = r_q.rdata;
  assign internal_reset_out = r_q.int_rst;
  assign io_load_init_out = r_q.int_rst;
  assign fetch_vector_out = r_q.fetch;
  assign irq_out = |(r_q.irq_status & r_q.irq_mask);

endmodule // rss_reset_source_sequencer

// ==== dv/rss_seq_asserts.sv ====
// Checker on the reset sequencer ports
`timescale 1ns/100ps
module rss_seq_asserts #(
  parameter logic [23:0] TOUT_FAST_CYC = 24'h8,
  parameter logic [23:0] TOUT_SLOW_CYC = 24'h14
) (
  input wire logic core_clk_in, // Clock
  input wire logic rst_in, // Reset
  input wire logic supply_low_in, // Low supply
  input wire logic ext_reset_n_in, // Pin
  input wire logic wdt_timeout_in, // Watchdog
  input wire logic brownout_detector_in, // Brown-out
  input wire logic test_port_reset_in, // Test port
  input wire logic [3:0] clock_select_fuses_in, // Delay fuses
  input wire logic brownout_enable_fuse_in, // Brown-out enable
  input wire logic reg_rd_in, // Read strobe
  input wire logic [7:0] reg_rdata_out, // Read data
  input wire logic io_force_init_out, // Port force
  input wire logic internal_reset_out, // Reset
  input wire logic io_load_init_out, // Load
  input wire logic fetch_vector_out // Fetch
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  logic [23:0] need;
  logic [23:0] cnt_q;
  assign need = (clock_select_fuses_in == 4'h0) ? 24'h1 :
    (clock_select_fuses_in[0] ? TOUT_SLOW_CYC : TOUT_FAST_CYC);
  // Unbroken reset cycles, compared with the selected stretch at release
  always_ff @(posedge core_clk_in) begin
    cnt_q <= (rst_in || !internal_reset_out) ? 24'h0 : cnt_q + 24'h1;
  end
  sequence s_tst_held;
    test_port_reset_in [*6];
  endsequence
  sequence s_por_held;
    supply_low_in [*6];
  endsequence
  chk_force_raw: assert property (io_force_init_out == (supply_low_in | !ext_reset_n_in |
    wdt_timeout_in | (brownout_enable_fuse_in & brownout_detector_in) | test_port_reset_in))
    else $error("port force mismatch");
  chk_wdt_entry: assert property (wdt_timeout_in |-> ##[1:2] internal_reset_out)
    else $error("watchdog pulse gave no reset");
  chk_load_track: assert property (io_load_init_out == internal_reset_out)
    else $error("load differs from reset");
  chk_fetch_edge: assert property ($fell(internal_reset_out) |-> ##[0:1] fetch_vector_out)
    else $error("no fetch at release");
  chk_stretch_len: assert property ($fell(internal_reset_out) |-> cnt_q >= need)
    else $error("stretch too short");
  chk_tst_hold: assert property (s_tst_held |-> internal_reset_out)
    else $error("test port not holding reset");
  chk_por_hold: assert property (s_por_held |-> internal_reset_out)
    else $error("low supply not holding reset");
  chk_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data outside read cycle");
endmodule // rss_seq_asserts
bind rss_reset_source_sequencer rss_seq_asserts #(.TOUT_FAST_CYC(TOUT_FAST_CYC),
  .TOUT_SLOW_CYC(TOUT_SLOW_CYC)) u_chk (.*);

// ==== dv/rss_src_model.sv ====
// Model of the reset requesters outside the sequencer
`timescale 1ns/100ps
module rss_src_model (
  input wire logic clk_in, // Clock
  input wire logic [4:0] req_in, // por, pin, bod, wdt, test
  output logic supply_low_out, // Low supply
  output logic ext_reset_n_out, // Pin
  output logic wdt_timeout_out, // Watchdog
  output logic brownout_out, // Brown-out
  output logic test_port_out // Test port
);
  logic wdt_q;
  always_ff @(posedge clk_in) begin
    wdt_q <= req_in[3];
  end
  // A held request still gives a single pulse, as a real timeout would
  assign wdt_timeout_out = req_in[3] & !wdt_q;
  assign supply_low_out = req_in[0];
  assign ext_reset_n_out = !req_in[1];
  assign brownout_out = req_in[2];
  assign test_port_out = req_in[4];
endmodule // rss_src_model

// ==== dv/rss_reset_source_sequencer_tb.sv ====
// Self-checking bench for the reset source sequencer
`timescale 1ns/100ps
module rss_reset_source_sequencer_tb;
  import rss_pkg::*;
  logic clk, rst, wr, rd, sl, pn, wd, bo, tp, irq, irst, lg;
  logic [3:0] fs;
  logic [4:0] req;
  rss_addr_type addr;
  logic [7:0] wdata, rdata;
  int fail_count, comparisons;
  int kind [6] = '{3, 4, 1, 2, 3, 0};
  logic [7:0] exp [6] = '{8'h08, 8'h18, 8'h1a, 8'h0e, 8'h0e, 8'h01};
  rss_reset_source_sequencer #(.TOUT_FAST_CYC(24'h8), .TOUT_SLOW_CYC(24'h14)) i_dut (
    .core_clk_in(clk), .rst_in(rst), .supply_low_in(sl), .ext_reset_n_in(pn),
    .wdt_timeout_in(wd), .brownout_detector_in(bo), .test_port_reset_in(tp),
    .clock_select_fuses_in(fs), .brownout_enable_fuse_in(1'b1), .legacy_fuse_in(lg),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .io_force_init_out(), .internal_reset_out(irst),
    .io_load_init_out(), .fetch_vector_out(), .irq_out(irq));
  rss_src_model i_src (.clk_in(clk), .req_in(req), .supply_low_out(sl),
    .ext_reset_n_out(pn), .wdt_timeout_out(wd), .brownout_out(bo), .test_port_out(tp));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chk(input logic [7:0] got, input logic [7:0] want);
    comparisons++;
    if (got !== want) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task summarize;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task wr_reg(input rss_addr_type a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input rss_addr_type a, input logic [7:0] want);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, want);
  endtask
  // Cycles from source release to reset release: the stretch plus a little sync latency
  task wait_rel(input int lo);
    int n;
    n = 0;
    #1;
    while (irst !== 1'b0 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(8'(n >= lo && n <= lo + 4), 8'h01);
    chk(8'(irst), 8'h00);
  endtask
  task ev(input int k, input int len);
    @(posedge clk);
    req[k] <= 1'b1;
    repeat (len) @(posedge clk);
    req[k] <= 1'b0;
  endtask
  initial begin
    rst = 1'b1; req = 5'h00; addr = 2'h0; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
    fail_count = 0; comparisons = 0;
    fs = 4'h2;
    lg = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    wait_rel(8);
    rd_reg(2'h0, 8'h00);
    wr_reg(2'h2, 8'h1f);
    rd_reg(2'h2, 8'h1f);
    wr_reg(2'h3, 8'hff);
    rd_reg(2'h3, 8'h00);
    ev(2, 100);
    repeat (4) @(posedge clk);
    chk(8'(irst), 8'h00);
    rd_reg(2'h0, 8'h00);
    $display("register and dip test done");
    for (int i = 0; i < 6; i++) begin
      ev(kind[i], (kind[i] == 2) ? 210 : ((kind[i] == 3) ? 1 : 12));
      wait_rel(8);
      rd_reg(2'h0, exp[i]);
      chk(8'(irq), 8'h01);
      wr_reg(2'h1, 8'h1f);
      @(posedge clk);
      #1 chk(8'(irq), 8'h00);
      $display("source %0d test done", kind[i]);
    end
    wr_reg(2'h2, 8'h00);
    ev(3, 1);
    wait_rel(8);
    rd_reg(2'h0, 8'h09);
    chk(8'(irq), 8'h00);
    wr_reg(2'h0, 8'hff);
    rd_reg(2'h0, 8'h09);
    wr_reg(2'h0, 8'h00);
    rd_reg(2'h0, 8'h00);
    $display("mask and clear test done");
    for (int f = 1; f >= 0; f--) begin
      @(posedge clk);
      fs <= 4'(f);
      ev(3, 1);
      wait_rel(f ? 20 : 1);
    end
    @(posedge clk);
    fs <= 4'h2;
    lg <= 1'b1;
    ev(3, 1);
    wait_rel(8);
    rd_reg(2'h0, 8'h00);
    ev(1, 12);
    wait_rel(8);
    rd_reg(2'h0, 8'h02);
    $display("fuse and legacy test done");
    summarize();
  end
  initial begin
    #100000;
    fail_count++;
    summarize();
  end
endmodule // rss_reset_source_sequencer_tb
